// ===== src/qfe_pkg.sv
// shared constants for the queue flag, echo and power-down block
package qfe_pkg;
  localparam int unsigned DATA_W     = 40;
  localparam int unsigned DEPTH      = 8192;
  localparam int unsigned CNT_W      = 14;
  localparam int unsigned OFFS_W     = 13;
  localparam logic [OFFS_W-1:0] PAF_OFFS_RST = 13'h007f;
  localparam logic [OFFS_W-1:0] PAE_OFFS_RST = 13'h007f;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned RECOVER_PS    = 1000000;
  localparam int unsigned RECOVER_CYC   =
    (RECOVER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_CYC  = 4;
  localparam int unsigned RECOV_W    = 7;
  localparam int unsigned QUIET_W    = 3;
  typedef enum logic [1:0] {
    QFE_RUN     = 2'b00,
    QFE_DOWN    = 2'b01,
    QFE_RECOVER = 2'b10
  } qfe_pwr_t;
endpackage

// ===== src/qfe_queue_ctrl.sv
// per-queue control: partial reset, echo enable, output gating, flags
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Notes on behaviour
// - during partial reset only output enable and the power state gate
// - broadcast reset touches only its queue
// - standard: echo low when nonempty and selected
// - echo enable registered on read clock
// - fall-through: echo low when ready, nonempty and selected
// - empty queue forces echo enable high
// - data driven only with output enable, and chip select outside partial reset
// - read past last word: ready clears, echo high
// - timing select latched at master reset
// - sync almost-full updates on write edges only
// - sync almost-full clears a write cycle later
// - sync almost-empty clears a read cycle later
// - async almost-full: write sets, read clears
// - async almost-empty: read sets, write clears
// - one microsecond recovery after power-down
// - power-down keeps config, disables serial ports
// - power-down holds flags, floats outputs
// ---------------------------------------------------------------------
module qfe_queue_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        flag_timing_sel,
  input  wire logic                        fall_through_mode,
  input  wire logic                        queue_part_reset_n,
  input  wire logic                        power_down_n,
  input  wire logic                        wr_strobe,
  input  wire logic                        wr_chip_sel_n,
  input  wire logic [qfe_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        rd_strobe,
  input  wire logic                        rd_chip_sel_n,
  input  wire logic                        rd_en_n,
  input  wire logic                        out_en_n,
  input  wire logic [qfe_pkg::OFFS_W-1:0]  paf_offset,
  input  wire logic [qfe_pkg::OFFS_W-1:0]  pae_offset,
  input  wire logic                        offs_load,
  output logic      [qfe_pkg::DATA_W-1:0]  rd_data,
  output logic      [qfe_pkg::DATA_W-1:0]  rd_data_oe,
  output logic                             echo_rd_en_n,
  output logic                             empty_flag_n,
  output logic                             full_flag_n,
  output logic                             almost_full_n,
  output logic                             almost_empty_n,
  output logic                             offs_port_active,
  output logic                             ready
);
  // ---------------------------------------------------------------------
  // storage and occupancy
  // ---------------------------------------------------------------------
  logic [qfe_pkg::DATA_W-1:0] mem [qfe_pkg::DEPTH];
  logic [qfe_pkg::CNT_W-2:0]  wr_ptr;
  logic [qfe_pkg::CNT_W-2:0]  rd_ptr;
  logic [qfe_pkg::CNT_W-1:0]  count;
  logic [qfe_pkg::DATA_W-1:0] out_reg;
  logic                       out_valid;
  logic [qfe_pkg::OFFS_W-1:0] paf_offs;
  logic [qfe_pkg::OFFS_W-1:0] pae_offs;
  qfe_pkg::qfe_pwr_t          pwr;
  logic [qfe_pkg::RECOV_W-1:0] recov_cnt;
  logic                       active;
  logic                       prst;
  logic                       do_wr;
  logic                       do_rd;
  logic                       load_out;
  logic                       mem_empty;
  logic                       rd_req;

  assign active    = (pwr == qfe_pkg::QFE_RUN);
  assign prst      = !queue_part_reset_n;
  assign mem_empty = (count == '0);
  assign rd_req    = rd_strobe && !rd_chip_sel_n && !rd_en_n;
  // host strobes only with nothing enabled around power-down and partial reset
  assign do_wr = active && !prst && wr_strobe && !wr_chip_sel_n &&
                 (count != qfe_pkg::CNT_W'(qfe_pkg::DEPTH));
  // fall-through preloads the output register when it is free
  assign load_out = active && !prst && !mem_empty &&
                    (fall_through_mode ? (!out_valid || rd_req) : rd_req);
  assign do_rd = load_out;

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // reset here is local to this queue, other queues are untouched
  always_ff @(posedge core_clk) begin
    if (rst || prst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{(qfe_pkg::CNT_W-1){1'b0}}, do_wr}
                     - {{(qfe_pkg::CNT_W-1){1'b0}}, do_rd};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || prst) begin
      out_reg   <= '0;
      out_valid <= 1'b0;
    end else if (load_out) begin
      out_reg   <= mem[rd_ptr];
      out_valid <= 1'b1;
    end else if (fall_through_mode && rd_req && active) begin
      out_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // echo read enable
  // ---------------------------------------------------------------------
  // registered on the read strobe edge so it tracks the read clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      echo_rd_en_n <= 1'b1;
    end else if (rd_strobe) begin
      if (fall_through_mode) begin
        echo_rd_en_n <= !(out_valid && rd_req &&
                          !mem_empty);
      end else begin
        echo_rd_en_n <= !(!mem_empty && rd_req);
      end
    end
  end

  // ---------------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      paf_offs  <= qfe_pkg::PAF_OFFS_RST;
      pae_offs  <= qfe_pkg::PAE_OFFS_RST;
    end else begin
      if (rst == 1'b0 && pwr == qfe_pkg::QFE_RUN && offs_load) begin
        paf_offs <= paf_offset;
        pae_offs <= pae_offset;
      end
    end
  end

  // timing select caught while master reset is held
  logic sync_cap;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_cap <= flag_timing_sel;
    end
  end
  assign offs_port_active = active;

  logic af_level;
  logic ae_level;
  assign af_level = ({1'b0, count} >=
                     {1'b0, qfe_pkg::CNT_W'(qfe_pkg::DEPTH)} -
                     {2'b00, paf_offs});
  assign ae_level = (count <= {1'b0, pae_offs});

  always_ff @(posedge core_clk) begin
    if (rst || prst) begin
      almost_full_n  <= 1'b1;
      almost_empty_n <= 1'b0;
      empty_flag_n   <= 1'b0;
      full_flag_n    <= 1'b1;
    end else if (active) begin
      empty_flag_n <= fall_through_mode ? out_valid : !mem_empty;
      full_flag_n  <= (count != qfe_pkg::CNT_W'(qfe_pkg::DEPTH));
      if (sync_cap) begin
        // sync: follows level on the own edge, one cycle behind
        if (wr_strobe) begin
          almost_full_n <= !af_level;
        end
        if (rd_strobe) begin
          almost_empty_n <= !ae_level;
        end
      end else begin
        if (wr_strobe && af_level) begin
          almost_full_n <= 1'b0;
        end else if (rd_strobe && !af_level) begin
          almost_full_n <= 1'b1;
        end
        if (rd_strobe && ae_level) begin
          almost_empty_n <= 1'b0;
        end else if (wr_strobe && !ae_level) begin
          almost_empty_n <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // power-down sequencing
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr       <= qfe_pkg::QFE_RUN;
      recov_cnt <= '0;
    end else begin
      case (pwr)
        qfe_pkg::QFE_RUN: begin
          if (!power_down_n) begin
            pwr <= qfe_pkg::QFE_DOWN;
          end
        end
        qfe_pkg::QFE_DOWN: begin
          if (power_down_n) begin
            pwr       <= qfe_pkg::QFE_RECOVER;
            recov_cnt <= qfe_pkg::RECOV_W'(qfe_pkg::RECOVER_CYC - 1);
          end
        end
        qfe_pkg::QFE_RECOVER: begin
          if (!power_down_n) begin
            pwr <= qfe_pkg::QFE_DOWN;
          end else if (recov_cnt == '0) begin
            pwr <= qfe_pkg::QFE_RUN;
          end else begin
            recov_cnt <= recov_cnt - 1'b1;
          end
        end
        default: pwr <= qfe_pkg::QFE_RUN;
      endcase
    end
  end

  assign ready = active;

  // ---------------------------------------------------------------------
  // output bus
  // ---------------------------------------------------------------------
  // partial reset leaves the bus to output enable and the power state alone
  logic bus_on;
  assign bus_on = active && !out_en_n &&
                  (prst || !rd_chip_sel_n);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data    <= '0;
      rd_data_oe <= '0;
    end else begin
      rd_data    <= out_reg;
      rd_data_oe <= {qfe_pkg::DATA_W{bus_on}};
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  // threshold tests kept apart from the flag logic they check
  logic af_chk;
  logic ae_chk;
  assign af_chk = ({1'b0, count} + {2'b00, paf_offs}) >=
                  {1'b0, qfe_pkg::CNT_W'(qfe_pkg::DEPTH)};
  assign ae_chk = ({1'b0, pae_offs} >= count);

  echo_empty_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (rd_strobe && !fall_through_mode && mem_empty) |=> echo_rd_en_n)
    else $error("echo enable low on empty queue");
  echo_std_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (rd_strobe && !fall_through_mode && !mem_empty && rd_req)
    |=> !echo_rd_en_n)
    else $error("echo enable missed a read");
  echo_ft_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (rd_strobe && fall_through_mode && !out_valid) |=> echo_rd_en_n)
    else $error("echo enable low without ready word");
  echo_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !rd_strobe |=> $stable(echo_rd_en_n))
    else $error("echo enable moved off read edge");
  bus_gate_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!prst && (rd_chip_sel_n || out_en_n)) |=> (rd_data_oe == '0))
    else $error("bus driven while deselected");
  pd_float_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (pwr != qfe_pkg::QFE_RUN) |=> (rd_data_oe == '0))
    else $error("bus driven in power-down");
  pd_flags_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (pwr == qfe_pkg::QFE_DOWN && $past(pwr) == qfe_pkg::QFE_DOWN &&
     !prst) |-> ($stable(almost_full_n) && $stable(empty_flag_n)))
    else $error("flag moved during power-down");
  af_sync_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (sync_cap && active && !prst && !wr_strobe) |=> $stable(almost_full_n))
    else $error("sync almost-full moved off write edge");
  recov_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ($past(pwr) == qfe_pkg::QFE_DOWN && pwr == qfe_pkg::QFE_RECOVER)
    |-> !ready [*8])
    else $error("resumed before recovery");
  reset_bus_on_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (prst && active && !out_en_n) |=> (rd_data_oe == '1))
    else $error("bus not driven during partial reset");
  reset_bus_off_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (prst && out_en_n) |=> (rd_data_oe == '0))
    else $error("bus driven with output enable off");
  echo_last_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (fall_through_mode && rd_req && mem_empty && active && !prst)
    |=> (echo_rd_en_n && !out_valid))
    else $error("read past last word kept ready or echo low");
  af_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (active && !prst && wr_strobe && af_chk) |=> !almost_full_n)
    else $error("almost-full missed its threshold");
  af_sync_clr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (sync_cap && active && !prst && wr_strobe && !af_chk) |=> almost_full_n)
    else $error("sync almost-full did not clear");
  af_async_clr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!sync_cap && active && !prst && rd_strobe && !af_chk) |=> almost_full_n)
    else $error("async almost-full did not clear on read");
  ae_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (active && !prst && rd_strobe && ae_chk) |=> !almost_empty_n)
    else $error("almost-empty missed its threshold");
  ae_sync_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (sync_cap && active && !prst && !rd_strobe) |=> $stable(almost_empty_n))
    else $error("sync almost-empty moved off read edge");
  ae_async_clr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!sync_cap && active && !prst && wr_strobe && !ae_chk) |=> almost_empty_n)
    else $error("async almost-empty did not clear on write");
  part_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    prst |=> (count == '0))
    else $error("partial reset left words behind");
  pd_offset_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!active && offs_load) |=> ($stable(paf_offs) && $stable(pae_offs)))
    else $error("offset changed during power-down");
  timing_latch_a: assert property (
    @(posedge core_clk)
    rst |=> (sync_cap == $past(flag_timing_sel)))
    else $error("timing select not latched in reset");
endmodule
`default_nettype wire

// ===== test/qfe_host.sv
// host model driving the queue write and read ports
`timescale 1ns/1ps
`default_nettype none
module qfe_host (
  input  wire logic                       core_clk,
  output var  logic                       wr_strobe,
  output var  logic                       wr_chip_sel_n,
  output var  logic [qfe_pkg::DATA_W-1:0] wr_data,
  output var  logic                       rd_strobe,
  output var  logic                       rd_chip_sel_n,
  output var  logic                       rd_en_n
);
  initial begin
    wr_strobe     = 1'b0;
    wr_chip_sel_n = 1'b1;
    wr_data       = '0;
    rd_strobe     = 1'b0;
    rd_chip_sel_n = 1'b1;
    rd_en_n       = 1'b1;
  end
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  // released data flips so a stale copy never passes as a match
  task automatic wr(input logic [qfe_pkg::DATA_W-1:0] d, input logic cs_n);
    wr_chip_sel_n = cs_n;
    wr_data       = d;
    wr_strobe     = 1'b1;
    step();
    wr_strobe = 1'b0;
    wr_data   = ~d;
    step();
  endtask
  // select a cycle ahead of the read edge
  task automatic rd(input logic cs_n, input logic en_n);
    rd_chip_sel_n = cs_n;
    step();
    rd_en_n   = en_n;
    rd_strobe = 1'b1;
    step();
    rd_strobe = 1'b0;
    rd_en_n   = 1'b1;
  endtask
  // edges with nothing enabled before power-down
  task automatic quiet();
    repeat (qfe_pkg::QUIET_CYC) begin
      wr('0, 1'b1);
      rd(1'b0, 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ===== test/queue_flag_echo_powerdown_bench.sv
// self-checking bench for the per-queue control block
`timescale 1ns/1ps
`default_nettype none
module queue_flag_echo_powerdown_bench;
  localparam logic [39:0] ONES = '1;
  logic                       core_clk, rst, flag_timing_sel;
  logic                       fall_through_mode, queue_part_reset_n;
  logic                       power_down_n, out_en_n, offs_load;
  logic                       wr_strobe, wr_chip_sel_n, rd_strobe;
  logic                       rd_chip_sel_n, rd_en_n, ready;
  logic [qfe_pkg::DATA_W-1:0] wr_data, rd_data, rd_data_oe;
  logic [qfe_pkg::OFFS_W-1:0] paf_offset, pae_offset;
  logic                       echo_rd_en_n, empty_flag_n, full_flag_n;
  logic                       almost_full_n, almost_empty_n;
  logic                       offs_port_active;
  int                         fails = 0;
  int                         checks_done = 0;
  int                         cycles = 0;
  qfe_queue_ctrl u_dut (.core_clk, .rst, .flag_timing_sel,
    .fall_through_mode, .queue_part_reset_n, .power_down_n, .wr_strobe,
    .wr_chip_sel_n, .wr_data, .rd_strobe, .rd_chip_sel_n, .rd_en_n,
    .out_en_n, .paf_offset, .pae_offset, .offs_load, .rd_data,
    .rd_data_oe, .echo_rd_en_n, .empty_flag_n, .full_flag_n,
    .almost_full_n, .almost_empty_n, .offs_port_active, .ready);
  qfe_host u_host (.core_clk, .wr_strobe, .wr_chip_sel_n, .wr_data,
    .rd_strobe, .rd_chip_sel_n, .rd_en_n);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run is under two hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic sel);
    rst = 1'b1;
    flag_timing_sel = sel;
    repeat (5) u_host.step();
    rst = 1'b0;
    chk(echo_rd_en_n, 1'b1);
    chk(almost_empty_n, 1'b0);
    chk(empty_flag_n, 1'b0);
    chk(full_flag_n, 1'b1);
  endtask
  task automatic load(input logic [12:0] af, input logic [12:0] ae);
    paf_offset = af;
    pae_offset = ae;
    offs_load  = 1'b1;
    u_host.step();
    offs_load  = 1'b0;
    u_host.step();
  endtask
  // af threshold 8192-8189 = 3 words, ae threshold 2 words
  task automatic t_sync();
    do_reset(1'b1);
    load(13'h1ffd, 13'h0002);
    u_host.rd(1'b0, 1'b0);
    chk(echo_rd_en_n, 1'b1);
    for (int i = 1; i <= 3; i++)
      u_host.wr(40'h11_1111_1111 * i, 1'b0);
    // idle write edge lets the sync flag see the third word
    u_host.wr('0, 1'b1);
    u_host.rd(1'b0, 1'b1);
    chk(echo_rd_en_n, 1'b1);
    chk(almost_empty_n, 1'b1);
    chk(almost_full_n, 1'b0);
    u_host.rd(1'b0, 1'b0);
    chk(echo_rd_en_n, 1'b0);
    chk(almost_full_n, 1'b0);
    u_host.wr('0, 1'b1);
    chk(almost_full_n, 1'b1);
    chk(rd_data, 40'h11_1111_1111);
    chk(rd_data_oe, ONES);
    out_en_n = 1'b1;
    repeat (2) u_host.step();
    chk(rd_data_oe, '0);
    out_en_n = 1'b0;
    repeat (3) u_host.rd(1'b0, 1'b0);
    chk(echo_rd_en_n, 1'b1);
    chk(almost_empty_n, 1'b0);
  endtask
  // af threshold one word, ae offset zero
  task automatic t_async();
    do_reset(1'b0);
    load(13'h1fff, 13'h0000);
    u_host.wr(40'h5a, 1'b0);
    u_host.wr('0, 1'b1);
    chk(almost_full_n, 1'b0);
    chk(almost_empty_n, 1'b1);
    u_host.rd(1'b0, 1'b0);
    u_host.rd(1'b0, 1'b1);
    chk(almost_full_n, 1'b1);
    chk(almost_empty_n, 1'b0);
  endtask
  task automatic t_prs();
    u_host.wr(40'h77, 1'b0);
    repeat (4) u_host.rd(1'b1, 1'b1);
    repeat (4) u_host.wr('0, 1'b1);
    queue_part_reset_n = 1'b0;
    repeat (2) u_host.step();
    chk(rd_data_oe, ONES);
    out_en_n = 1'b1;
    repeat (2) u_host.step();
    chk(rd_data_oe, '0);
    out_en_n = 1'b0;
    queue_part_reset_n = 1'b1;
    repeat (2) u_host.step();
    chk(empty_flag_n, 1'b0);
    chk(rd_data_oe, '0);
  endtask
  task automatic t_pd();
    u_host.wr(40'h3c, 1'b0);
    u_host.quiet();
    chk(rd_data_oe, ONES);
    power_down_n = 1'b0;
    repeat (2) u_host.step();
    chk(rd_data_oe, '0);
    chk(empty_flag_n, 1'b1);
    chk(offs_port_active, 1'b0);
    power_down_n = 1'b1;
    repeat (30) u_host.step();
    chk(ready, 1'b0);
    for (int i = 0; i < 60 && ready !== 1'b1; i++)
      u_host.step();
    chk(ready, 1'b1);
    chk(offs_port_active, 1'b1);
  endtask
  // fall-through: first word preloads, read past last raises echo
  task automatic t_ft();
    fall_through_mode = 1'b1;
    do_reset(1'b0);
    u_host.wr(40'ha1, 1'b0);
    u_host.wr(40'hb2, 1'b0);
    chk(empty_flag_n, 1'b1);
    chk(rd_data, 40'ha1);
    u_host.rd(1'b0, 1'b0);
    chk(echo_rd_en_n, 1'b0);
    u_host.step();
    chk(rd_data, 40'hb2);
    u_host.rd(1'b0, 1'b0);
    chk(echo_rd_en_n, 1'b1);
    u_host.step();
    chk(empty_flag_n, 1'b0);
  endtask
  // fall-through is switched on only in the last scenario
  initial begin
    fall_through_mode  = 1'b0;
    queue_part_reset_n = 1'b1;
    power_down_n       = 1'b1;
    out_en_n           = 1'b0;
    offs_load          = 1'b0;
    paf_offset         = '0;
    pae_offset         = '0;
    t_sync();
    t_async();
    t_prs();
    t_pd();
    t_ft();
    finish_test();
  end
endmodule
`default_nettype wire
